// *** asrc_defs.svh ***
// Timing and geometry constants for the asynchronous SRAM host controller.
// Assumes a 40 MHz system clock; times are in ns, counts in clock cycles.
`ifndef ASRC_DEFS_SVH
`define ASRC_DEFS_SVH

`define ASRC_ADDR_W 15
`define ASRC_DATA_W 8
`define ASRC_CLK_PERIOD_NS 25
// Slowest speed grade figures, so one controller serves every grade
`define ASRC_READ_CYCLE_TIME_NS 100
`define ASRC_WRITE_CYCLE_TIME_NS 100
`define ASRC_ADDR_TO_END_NS 90
`define ASRC_WRITE_PULSE_NS 65
`define ASRC_WRITE_DATA_SETUP_NS 35
`define ASRC_STROBE_TO_FLOAT_DELAY_NS 45
`define ASRC_OE_FLOAT_NS 45
// Least times round up
`define ASRC_READ_CYC \
    ((`ASRC_READ_CYCLE_TIME_NS + `ASRC_CLK_PERIOD_NS - 1) \
    / `ASRC_CLK_PERIOD_NS)
`define ASRC_WP_CYC \
    ((`ASRC_ADDR_TO_END_NS + `ASRC_CLK_PERIOD_NS - 1) \
    / `ASRC_CLK_PERIOD_NS)
`define ASRC_FLOAT_CYC \
    ((`ASRC_STROBE_TO_FLOAT_DELAY_NS + `ASRC_CLK_PERIOD_NS - 1) \
    / `ASRC_CLK_PERIOD_NS)
`define ASRC_TURN_CYC \
    ((`ASRC_OE_FLOAT_NS + `ASRC_CLK_PERIOD_NS - 1) \
    / `ASRC_CLK_PERIOD_NS)

`endif

// *** asrc_pkg.sv ***
// Types for the asynchronous SRAM host controller.
// Assumes asrc_defs.svh is on the include path.
`include "asrc_defs.svh"

package asrc_pkg;

    typedef struct packed {
        logic write;
        logic [`ASRC_ADDR_W-1:0] addr;
        logic [`ASRC_DATA_W-1:0] wdata;
    } asrc_req_t;

    typedef struct packed {
        logic chip_sel_n;
        logic out_en_n;
        logic write_n;
        logic [`ASRC_ADDR_W-1:0] address_inputs;
    } asrc_pins_t;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_READ = 3'b001,
        ST_WSET = 3'b010,
        ST_WPULSE = 3'b011,
        ST_TURN = 3'b100
    } asrc_state_t;

endpackage

// *** asrc_ctrl.sv ***
// Host-side controller for a 32K x 8 asynchronous static RAM.
// Assumes the RAM pins are wired to pins_o and the data line triplet;
// the testbench resolves the shared data lines from the enables.
// Summary of operation
// - Host keeps address stable for the whole write cycle.
// - Host holds output enable high throughout every write cycle.
// - Read cycle at least 70, 90 or 100 ns; data valid within it.
// - Address valid at least 65, 80 or 90 ns before write end.
// - Write data set up 30, 30 or 35 ns before end; zero hold.
`timescale 1ns/1ps
`default_nettype none
`include "asrc_defs.svh"

module asrc_ctrl
    import asrc_pkg::*;
(
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic req_valid,
    input wire asrc_pkg::asrc_req_t req,
    output logic req_ready,
    output logic [`ASRC_DATA_W-1:0] rdata,
    output logic rdata_valid,
    output asrc_pkg::asrc_pins_t pins_o,
    input wire logic [`ASRC_DATA_W-1:0] data_lines_i,
    output logic [`ASRC_DATA_W-1:0] data_lines_o,
    output logic data_lines_oe_n
);
    import asrc_pkg::*;

    localparam logic [3:0] READ_CYC = 4'(`ASRC_READ_CYC);
    localparam logic [3:0] WP_CYC = 4'(`ASRC_WP_CYC);
    localparam logic [3:0] TURN_CYC = 4'(`ASRC_TURN_CYC);

    asrc_state_t state_reg;
    logic [3:0] cnt_reg;

    ////////////////////////////////////////////////////////////////////////
    // Sequencer

    always_ff @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            state_reg <= ST_IDLE;
            cnt_reg <= 4'h0;
        end
        else
        begin
            unique case (state_reg)
                ST_IDLE:
                begin
                    if (req_valid)
                    begin
                        cnt_reg <= 4'h0;
                        // Writes get one setup cycle so write falls after
                        // select with output enable already high
                        state_reg <= req.write ? ST_WSET : ST_READ;
                    end
                end
                ST_READ:
                begin
                    cnt_reg <= cnt_reg + 4'h1;
                    if (cnt_reg == READ_CYC - 4'h1)
                    begin
                        cnt_reg <= 4'h0;
                        state_reg <= ST_TURN;
                    end
                end
                ST_WSET:
                begin
                    state_reg <= ST_WPULSE;
                end
                ST_WPULSE:
                begin
                    cnt_reg <= cnt_reg + 4'h1;
                    if (cnt_reg == WP_CYC - 4'h1)
                    begin
                        cnt_reg <= 4'h0;
                        state_reg <= ST_TURN;
                    end
                end
                ST_TURN:
                begin
                    // Memory output float time before the next owner drives
                    cnt_reg <= cnt_reg + 4'h1;
                    if (cnt_reg == TURN_CYC - 4'h1)
                    begin
                        cnt_reg <= 4'h0;
                        state_reg <= ST_IDLE;
                    end
                end
                default:
                begin
                    state_reg <= ST_IDLE;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Pins

    always_ff @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            pins_o.chip_sel_n <= 1'b1;
            pins_o.out_en_n <= 1'b1;
            pins_o.write_n <= 1'b1;
            pins_o.address_inputs <= '0;
            data_lines_o <= '0;
            data_lines_oe_n <= 1'b1;
        end
        else
        begin
            if (state_reg == ST_IDLE && req_valid)
            begin
                // Address only moves while write is high
                pins_o.address_inputs <= req.addr;
                data_lines_o <= req.wdata;
                pins_o.chip_sel_n <= 1'b0;
                pins_o.out_en_n <= req.write;
                data_lines_oe_n <= ~req.write;
            end
            else if (state_reg == ST_WSET)
            begin
                pins_o.write_n <= 1'b0;
            end
            else if (state_reg == ST_WPULSE && cnt_reg == WP_CYC - 4'h1)
            begin
                // Write and select rise together; data held one more cycle
                pins_o.write_n <= 1'b1;
                pins_o.chip_sel_n <= 1'b1;
            end
            else if (state_reg == ST_READ && cnt_reg == READ_CYC - 4'h1)
            begin
                pins_o.chip_sel_n <= 1'b1;
                pins_o.out_en_n <= 1'b1;
            end
            else if (state_reg == ST_TURN)
            begin
                data_lines_oe_n <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read capture and handshake

    always_ff @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            rdata <= '0;
            rdata_valid <= 1'b0;
        end
        else
        begin
            // Sample at the last cycle of the full read time, which covers
            // both the select and output-enable access delays
            rdata_valid <= state_reg == ST_READ && cnt_reg == READ_CYC - 4'h1;
            if (state_reg == ST_READ && cnt_reg == READ_CYC - 4'h1)
            begin
                rdata <= data_lines_i;
            end
        end
    end

    always_ff @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            req_ready <= 1'b0;
        end
        else
        begin
            req_ready <= state_reg == ST_TURN && cnt_reg == TURN_CYC - 4'h1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks

    no_oe_write_a: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        !pins_o.write_n |-> pins_o.out_en_n)
        else $error("output enable low during write");

    addr_stable_a: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        !pins_o.write_n |=> $stable(pins_o.address_inputs) || pins_o.write_n)
        else $error("address moved during write");

    write_pulse_a: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        $fell(pins_o.write_n) |-> !pins_o.write_n [*4])
        else $error("write pulse too short");

    data_hold_a: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        $rose(pins_o.write_n) |-> !data_lines_oe_n)
        else $error("write data released before write end");

    read_len_a: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        $fell(pins_o.chip_sel_n) && pins_o.out_en_n == 1'b0
        |-> !pins_o.chip_sel_n [*4])
        else $error("read cycle too short");

    read_done_a: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        $fell(pins_o.chip_sel_n) && !pins_o.out_en_n |-> ##4 rdata_valid)
        else $error("read data not captured at cycle end");

    no_contend_a: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        !pins_o.out_en_n |-> data_lines_oe_n)
        else $error("host drives while memory output enabled");

    idle_standby_a: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        state_reg == ST_IDLE |-> pins_o.chip_sel_n)
        else $error("select active while idle");

endmodule // asrc_ctrl

`default_nettype wire

// *** asrc_sram_model.sv ***
// Behavioural 32K x 8 asynchronous static RAM facing the host controller.
// Assumes the bench resolves the shared data lines from both enables.
`timescale 1ns/1ps
`default_nettype none
`include "asrc_defs.svh"

module asrc_sram_model #(
    // Just inside the slowest access, so the capture edge never races it
    parameter int T_ACC = 99,
    parameter int T_HOLD = 10
)
(
    input wire logic chip_sel_n,
    input wire logic out_en_n,
    input wire logic write_n,
    input wire logic [`ASRC_ADDR_W-1:0] address_inputs,
    input wire logic [`ASRC_DATA_W-1:0] data_in,
    output logic [`ASRC_DATA_W-1:0] data_out,
    output logic data_oe_n
);
    logic [`ASRC_DATA_W-1:0] mem [0:32767];
    logic rd_en;
    logic rd_en_d;
    logic wr_end;
    logic [`ASRC_ADDR_W-1:0] addr_h;
    logic [`ASRC_ADDR_W-1:0] addr_d;
    // Deselect means standby at once, the quickest legal power-down
    assign rd_en = !chip_sel_n && write_n;
    assign #(T_ACC) rd_en_d = rd_en;
    assign #(T_HOLD) addr_h = address_inputs;
    assign #(T_ACC) addr_d = address_inputs;
    // Select high, output enable high or write low floats the lines at once
    assign data_oe_n = !(rd_en && !out_en_n);
    // Unsettled data shows as the inverse so it never matches by luck
    assign data_out = (rd_en_d && addr_d == addr_h) ? mem[addr_h]
        : ~mem[addr_h];
    // Whichever strobe rises first ends the write
    assign wr_end = chip_sel_n | write_n;
    always @(posedge wr_end)
        mem[address_inputs] = data_in;
endmodule // asrc_sram_model
`default_nettype wire

// *** async_sram_32k_x8_tb.sv ***
// Self-checking bench for the asynchronous SRAM host controller.
// Assumes asrc_ctrl and asrc_sram_model; inputs change at falling edges.
`timescale 1ns/1ps
`default_nettype none
`include "asrc_defs.svh"

module async_sram_32k_x8_tb;
    import asrc_pkg::*;
    logic sys_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic req_valid = 1'b0;
    asrc_req_t req = '0;
    logic req_ready;
    logic [7:0] rdata;
    logic rdata_valid;
    asrc_pins_t pins_o;
    logic [7:0] data_lines_i;
    logic [7:0] host_o;
    logic host_oe_n;
    logic [7:0] mem_o;
    logic mem_oe_n;
    int n_errors = 0;
    int n_checks = 0;
    int wlen = 0;
    // Columns: write, address, write data, expected read data
    logic [31:0] rows [8] = '{32'h8000a500, 32'hffff5a00, 32'h000000a5,
        32'h7fff005a, 32'h80003c00, 32'h0000003c, 32'h9234ff00, 32'h123400ff};
    // Nobody driving: show the inverse of host_o, so a float reads as the inverse of the request write data
    assign data_lines_i = !host_oe_n ? host_o : !mem_oe_n ? mem_o : ~host_o;
    asrc_ctrl dut (.sys_clk(sys_clk), .sys_rst(sys_rst),
        .req_valid(req_valid), .req(req), .req_ready(req_ready),
        .rdata(rdata), .rdata_valid(rdata_valid), .pins_o(pins_o),
        .data_lines_i(data_lines_i), .data_lines_o(host_o),
        .data_lines_oe_n(host_oe_n));
    asrc_sram_model mem (.chip_sel_n(pins_o.chip_sel_n),
        .out_en_n(pins_o.out_en_n), .write_n(pins_o.write_n),
        .address_inputs(pins_o.address_inputs), .data_in(data_lines_i),
        .data_out(mem_o), .data_oe_n(mem_oe_n));
    ////////////////////////////////////////////////////////////////////////
    task automatic cmp(input string what, input logic [31:0] exp,
        input logic [31:0] got);
        n_checks++;
        if (got !== exp)
        begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic give_verdict;
        if (n_errors == 0 && n_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic run(input logic [31:0] row);
        int n;
        @(negedge sys_clk);
        req_valid = 1'b1;
        req = row[31:8];
        @(negedge sys_clk);
        req_valid = 1'b0;
        n = 1;
        while (!row[31] && rdata_valid !== 1'b1 && n < 20)
        begin
            @(negedge sys_clk);
            n++;
        end
        if (!row[31])
        begin
            cmp("read latency", 5, n);
            cmp("read data", row[7:0], rdata);
        end
        while (req_ready !== 1'b1 && n < 30)
        begin
            @(negedge sys_clk);
            n++;
        end
        if (n >= 20)
        begin
            cmp("handshake", 1, 0);
            give_verdict();
        end
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        forever #12.5 sys_clk = ~sys_clk;
    end
    // Wire watch: contention, write pulse length, steady write address
    always @(posedge sys_clk)
    begin
        if (!sys_rst && host_oe_n === 1'b0 && mem_oe_n === 1'b0)
            cmp("contention", 0, 1);
        if (!sys_rst && pins_o.write_n === 1'b0)
        begin
            wlen <= wlen + 1;
            cmp("oe in write", 1, pins_o.out_en_n);
            if (wlen > 0)
                cmp("write addr", req.addr, pins_o.address_inputs);
        end
        else if (wlen > 0 && !sys_rst)
        begin
            cmp("write pulse", `ASRC_WP_CYC, wlen);
            wlen <= 0;
        end
    end
    initial
    begin
        repeat (16) @(negedge sys_clk);
        sys_rst = 1'b0;
        cmp("pins reset", 18'h38000, pins_o);
        cmp("oe reset", 1, host_oe_n);
        cmp("flags reset", 0, {req_ready, rdata_valid, rdata});
        foreach (rows[i])
            run(rows[i]);
        // Reset in mid-write must drop every strobe at once
        @(negedge sys_clk);
        req_valid = 1'b1;
        req = 24'h810000;
        repeat (3) @(negedge sys_clk);
        sys_rst = 1'b1;
        req_valid = 1'b0;
        #1;
        cmp("pins mid reset", 18'h38000, pins_o);
        cmp("oe mid reset", 1, host_oe_n);
        repeat (2) @(negedge sys_clk);
        sys_rst = 1'b0;
        wlen = 0;
        run(rows[7]);
        run(rows[3]);
        give_verdict();
    end
endmodule // async_sram_32k_x8_tb
`default_nettype wire
